// ---- logic/hdtr_map.vh ----
/*
 * Register map, reset values, field positions, segment codes and decode
 * tables of the haptic waveform time offset register bank.
 * Assumes it is included by its bare name from the files under logic/.
 */
`ifndef HDTR_MAP_VH
`define HDTR_MAP_VH

// Register byte addresses.
`define HDTR_ADDR_POS_SUSTAIN 8'h0E
`define HDTR_ADDR_NEG_SUSTAIN 8'h0F
`define HDTR_ADDR_BRAKE 8'h10
`define HDTR_ADDR_ATV_CTRL 8'h11
`define HDTR_ADDR_ATV_FLOOR 8'h12

// Reset values.
`define HDTR_RST_OFFSET 8'h00
`define HDTR_RST_PEAK 2'h0
`define HDTR_RST_LOWPASS 2'h1
`define HDTR_RST_FLOOR 8'h19
`define HDTR_RDATA_NONE 8'h00

// Control register fields.
`define HDTR_PEAK_HI 3
`define HDTR_PEAK_LO 2
`define HDTR_LP_HI 1
`define HDTR_LP_LO 0
`define HDTR_CTRL_RSVD 4'h0

// Segment classes of a library waveform sample.
`define HDTR_SEG_NONE 3'h0
`define HDTR_SEG_OVERDRIVE 3'h1
`define HDTR_SEG_POS 3'h2
`define HDTR_SEG_NEG 3'h3
`define HDTR_SEG_BRAKE 3'h4

// Peak detection window codes and their lengths in ms.
`define HDTR_PEAK_C0 2'h0
`define HDTR_PEAK_C1 2'h1
`define HDTR_PEAK_C2 2'h2
`define HDTR_PEAK_MS0 6'h0A
`define HDTR_PEAK_MS1 6'h14
`define HDTR_PEAK_MS2 6'h1E
`define HDTR_PEAK_MS3 6'h28

// Low-pass cutoff codes and their frequencies in Hz.
`define HDTR_LP_C0 2'h0
`define HDTR_LP_C1 2'h1
`define HDTR_LP_C2 2'h2
`define HDTR_LP_HZ0 8'h64
`define HDTR_LP_HZ1 8'h7D
`define HDTR_LP_HZ2 8'h96
`define HDTR_LP_HZ3 8'hC8

`endif

// ---- logic/hdtr_seg_classify.v ----
/*
 * Combinational classifier that sorts one library waveform sample into its
 * segment class.
 * Assumes the playback engine flags overdrive samples and supplies the most
 * negative amplitude of the waveform being played.
 */
`include "hdtr_map.vh"

module hdtr_seg_classify (
    input wire [7:0] amp,          // Signed sample amplitude.
    input wire in_overdrive,       // Sample lies in the overdrive segment.
    input wire [7:0] wave_min_amp, // Signed most negative amplitude of the waveform.
    output reg [2:0] seg           // Segment class of the sample.
);

    wire signed [7:0] amp_s = amp;
    wire signed [7:0] min_s = wave_min_amp;

    // Overdrive wins, then the most negative value marks braking.
    always @* begin
        if (in_overdrive) begin
            seg = `HDTR_SEG_OVERDRIVE;
        end else if (amp_s < 0 && amp_s == min_s) begin
            seg = `HDTR_SEG_BRAKE;
        end else if (amp_s < 0) begin
            seg = `HDTR_SEG_NEG;
        end else if (amp_s > 0) begin
            seg = `HDTR_SEG_POS;
        end else begin
            seg = `HDTR_SEG_NONE;
        end
    end

endmodule

// ---- logic/hdtr_len_adjust.v ----
/*
 * Combinational length adjuster: adds a signed segment offset to the first
 * sample of a segment and carries any shortfall into later samples of the
 * same segment, so that a segment never goes below zero length.
 * Assumes the caller stores the carried shortfall between samples.
 */
module hdtr_len_adjust (
    input wire [7:0] len,      // Sample length in playback intervals.
    input wire [7:0] offset,   // Signed segment offset in playback intervals.
    input wire [7:0] debt,     // Shortfall left from earlier samples of the segment.
    input wire first,          // Sample opens a new segment.
    output wire [8:0] adj_len, // Adjusted sample length in playback intervals.
    output wire [7:0] debt_nxt // Shortfall to carry to the next sample.
);

    wire signed [9:0] len_s = {2'h0, len};
    wire signed [9:0] off_s = {{2{offset[7]}}, offset};
    wire signed [9:0] debt_s = {2'h0, debt};
    wire signed [9:0] sum = first ? (len_s + off_s) : (len_s - debt_s);
    wire signed [9:0] shortfall = 10'sh000 - sum;

    // A negative total empties the sample instead of wrapping.
    assign adj_len = sum[9] ? 9'h000 : sum[8:0];
    assign debt_nxt = sum[9] ? shortfall[7:0] : 8'h00;

endmodule

// ---- logic/hdtr_regs.v ----
/*
 * Waveform time offset register bank with the sample path it steers:
 * sustain and brake offsets retime library waveform segments, and the
 * audio_vibe_control and input floor set up the audio path.
 * Assumes a serial host front end on the same clock turns transactions into
 * single-cycle register strobes, and that the playback engine presents one
 * library sample per valid strobe, flagging the first sample of a waveform.
 * The loop mode and the sample_step_time are steady levels on the same
 * clock and are sampled together with each library sample.
 */
`include "hdtr_map.vh"

// Operation
// - Positive sustain stretched by signed offset intervals.
// - Non-overdrive positive samples are positive sustain.
// - Negative sustain stretched by signed offset intervals.
// - Non-overdrive negative samples other than the most negative are negative sustain.
// - Brake segment stretched by signed offset intervals.
// - Most negative samples form the brake segment; an overdrive one is classed as overdrive.
// - Brake offset acts only in open loop.
// - Offsets are two's complement, reset to zero.
// - Peak window codes give 10 to 40 ms.
// - Low-pass codes give 100-200 Hz, reset 125.
// - Audio below the input floor is ignored.
module hdtr_regs (
    input wire clk,                    // Device clock, 20 MHz.
    input wire resetn,                 // Synchronous reset, active low.
    input wire [7:0] reg_addr,         // Register address.
    input wire reg_wr,                 // Register write strobe.
    input wire [7:0] reg_wdata,        // Register write data.
    input wire reg_rd,                 // Register read strobe.
    output reg [7:0] reg_rdata,        // Read data, valid the cycle after reg_rd.
    input wire closed_loop,            // Closed-loop drive selected.
    input wire smp_valid,              // Library sample strobe.
    input wire wave_start,             // Sample is the first of a waveform.
    input wire [7:0] smp_amp,          // Signed sample amplitude.
    input wire [7:0] smp_len,          // Sample length in playback intervals.
    input wire smp_overdrive,          // Sample lies in the overdrive segment.
    input wire [7:0] wave_min_amp,     // Signed most negative amplitude of the waveform.
    input wire [4:0] sample_step_time, // Sample_step_time in ms.
    output reg out_valid,              // Adjusted sample strobe.
    output reg [7:0] out_amp,          // Amplitude of the adjusted sample.
    output reg [2:0] out_seg,          // Segment class of the adjusted sample.
    output reg [8:0] out_len,          // Adjusted length in playback intervals.
    output reg [15:0] out_ms,          // Adjusted length in ms.
    input wire audio_valid,            // Audio level sample strobe.
    input wire [7:0] audio_level,      // Audio level in floor code units.
    output reg atv_valid,              // Audio level passed the floor.
    output reg [7:0] atv_level,        // Passed audio level.
    output reg [5:0] atv_peak_ms,      // Selected peak detection window in ms.
    output reg [7:0] atv_cutoff_hz     // Selected low-pass cutoff in Hz.
);

    // Host-visible configuration registers and their next values.
    reg [7:0] pos_sustain_offset_r;
    reg [7:0] pos_sustain_offset_nxt;
    reg [7:0] neg_sustain_offset_r;
    reg [7:0] neg_sustain_offset_nxt;
    reg [7:0] brake_time_offset_r;
    reg [7:0] brake_time_offset_nxt;
    reg [1:0] atv_peak_window_r;
    reg [1:0] atv_peak_window_nxt;
    reg [1:0] atv_lowpass_select_r;
    reg [1:0] atv_lowpass_select_nxt;
    reg [7:0] atv_input_floor_r;
    reg [7:0] atv_input_floor_nxt;
    reg [7:0] rdata_nxt;

    // Segment run tracking and the offset chosen for the current sample.
    reg [2:0] prev_seg_r;
    reg [2:0] prev_seg_nxt;
    reg [7:0] debt_r;
    reg [7:0] debt_nxt;
    reg seg_open_r;
    reg seg_open_nxt;
    reg [7:0] seg_offset;

    // Next values of the registered sample and audio outputs.
    reg out_valid_nxt;
    reg [7:0] out_amp_nxt;
    reg [2:0] out_seg_nxt;
    reg [8:0] out_len_nxt;
    reg [15:0] out_ms_nxt;
    reg atv_valid_nxt;
    reg [7:0] atv_level_nxt;
    reg [5:0] atv_peak_ms_nxt;
    reg [7:0] atv_cutoff_hz_nxt;

    // Classifier and adjuster results for the sample on the inputs.
    wire [2:0] cur_seg;
    wire seg_first;
    wire [8:0] adj_len;
    wire [7:0] carry_len;
    wire [13:0] len_ms;

    // Table decodes of the control fields.
    function [5:0] peak_ms;
        input [1:0] code;
        begin
            case (code)
                `HDTR_PEAK_C0: peak_ms = `HDTR_PEAK_MS0;
                `HDTR_PEAK_C1: peak_ms = `HDTR_PEAK_MS1;
                `HDTR_PEAK_C2: peak_ms = `HDTR_PEAK_MS2;
                default: peak_ms = `HDTR_PEAK_MS3;
            endcase
        end
    endfunction

    function [7:0] cutoff_hz;
        input [1:0] code;
        begin
            case (code)
                `HDTR_LP_C0: cutoff_hz = `HDTR_LP_HZ0;
                `HDTR_LP_C1: cutoff_hz = `HDTR_LP_HZ1;
                `HDTR_LP_C2: cutoff_hz = `HDTR_LP_HZ2;
                default: cutoff_hz = `HDTR_LP_HZ3;
            endcase
        end
    endfunction

    // Audio at or above the floor is passed; below it is ignored.
    function floor_pass;
        input [7:0] level;
        input [7:0] limit;
        begin
            floor_pass = (level >= limit);
        end
    endfunction

    // Register writes land at the strobe edge; control bits 7 to 4 are
    // not stored and read back as zero.
    always @* begin
        pos_sustain_offset_nxt = pos_sustain_offset_r;
        neg_sustain_offset_nxt = neg_sustain_offset_r;
        brake_time_offset_nxt = brake_time_offset_r;
        atv_peak_window_nxt = atv_peak_window_r;
        atv_lowpass_select_nxt = atv_lowpass_select_r;
        atv_input_floor_nxt = atv_input_floor_r;
        if (reg_wr) begin
            case (reg_addr)
                `HDTR_ADDR_POS_SUSTAIN: pos_sustain_offset_nxt = reg_wdata;
                `HDTR_ADDR_NEG_SUSTAIN: neg_sustain_offset_nxt = reg_wdata;
                `HDTR_ADDR_BRAKE: brake_time_offset_nxt = reg_wdata;
                `HDTR_ADDR_ATV_CTRL: begin
                    atv_peak_window_nxt = reg_wdata[`HDTR_PEAK_HI:`HDTR_PEAK_LO];
                    atv_lowpass_select_nxt = reg_wdata[`HDTR_LP_HI:`HDTR_LP_LO];
                end
                `HDTR_ADDR_ATV_FLOOR: atv_input_floor_nxt = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Register reads; reserved control bits and unmapped addresses read zero.
    // A read in the same cycle as a write returns the old contents.
    always @* begin
        case (reg_addr)
            `HDTR_ADDR_POS_SUSTAIN: rdata_nxt = pos_sustain_offset_r;
            `HDTR_ADDR_NEG_SUSTAIN: rdata_nxt = neg_sustain_offset_r;
            `HDTR_ADDR_BRAKE: rdata_nxt = brake_time_offset_r;
            `HDTR_ADDR_ATV_CTRL: rdata_nxt = {`HDTR_CTRL_RSVD, atv_peak_window_r, atv_lowpass_select_r};
            `HDTR_ADDR_ATV_FLOOR: rdata_nxt = atv_input_floor_r;
            default: rdata_nxt = `HDTR_RDATA_NONE;
        endcase
    end

    always @(posedge clk) begin
        if (!resetn) begin
            pos_sustain_offset_r <= `HDTR_RST_OFFSET;
            neg_sustain_offset_r <= `HDTR_RST_OFFSET;
            brake_time_offset_r <= `HDTR_RST_OFFSET;
            atv_peak_window_r <= `HDTR_RST_PEAK;
            atv_lowpass_select_r <= `HDTR_RST_LOWPASS;
            atv_input_floor_r <= `HDTR_RST_FLOOR;
        end else begin
            pos_sustain_offset_r <= pos_sustain_offset_nxt;
            neg_sustain_offset_r <= neg_sustain_offset_nxt;
            brake_time_offset_r <= brake_time_offset_nxt;
            atv_peak_window_r <= atv_peak_window_nxt;
            atv_lowpass_select_r <= atv_lowpass_select_nxt;
            atv_input_floor_r <= atv_input_floor_nxt;
        end
    end

    // Read data is captured at the strobe edge and held until the next read.
    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= `HDTR_RDATA_NONE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Sort the sample on the inputs into its segment class.
    hdtr_seg_classify hdtr_seg_classify_inst (
        .amp(smp_amp),
        .in_overdrive(smp_overdrive),
        .wave_min_amp(wave_min_amp),
        .seg(cur_seg)
    );

    // Offset chosen by segment; overdrive and silence pass unchanged.
    // In closed loop the drive loop times braking, so the brake offset is kept but not applied.
    always @* begin
        case (cur_seg)
            `HDTR_SEG_POS: seg_offset = pos_sustain_offset_r;
            `HDTR_SEG_NEG: seg_offset = neg_sustain_offset_r;
            `HDTR_SEG_BRAKE: seg_offset = closed_loop ? `HDTR_RST_OFFSET : brake_time_offset_r;
            default: seg_offset = `HDTR_RST_OFFSET;
        endcase
    end

    // The offset is applied once per segment run, at its first sample.
    // A run opens on the first sample of a waveform, on the first sample
    // since reset and whenever the class changes. A shortfall left when the
    // class changes is dropped, because the adjuster reads the carried debt
    // only on samples that continue a run.
    assign seg_first = wave_start | ~seg_open_r | (cur_seg != prev_seg_r);

    // Add the offset on the first sample of a run and carry any shortfall.
    hdtr_len_adjust hdtr_len_adjust_inst (
        .len(smp_len),
        .offset(seg_offset),
        .debt(debt_r),
        .first(seg_first),
        .adj_len(adj_len),
        .debt_nxt(carry_len)
    );

    // A 9-bit length times a 5-bit interval fits the 14-bit product.
    assign len_ms = adj_len * sample_step_time;

    // Sample path next values; the data outputs hold between samples.
    always @* begin
        out_valid_nxt = smp_valid;
        prev_seg_nxt = prev_seg_r;
        debt_nxt = debt_r;
        seg_open_nxt = seg_open_r;
        out_amp_nxt = out_amp;
        out_seg_nxt = out_seg;
        out_len_nxt = out_len;
        out_ms_nxt = out_ms;
        if (smp_valid) begin
            prev_seg_nxt = cur_seg;
            debt_nxt = carry_len;
            seg_open_nxt = 1'h1;
            out_amp_nxt = smp_amp;
            out_seg_nxt = cur_seg;
            out_len_nxt = adj_len;
            out_ms_nxt = {2'h0, len_ms};
        end
    end

    // Audio path next values: floor gate plus decoded window and cutoff.
    always @* begin
        atv_valid_nxt = 1'h0;
        atv_level_nxt = atv_level;
        if (audio_valid && floor_pass(audio_level, atv_input_floor_r)) begin
            atv_valid_nxt = 1'h1;
            atv_level_nxt = audio_level;
        end
        atv_peak_ms_nxt = peak_ms(atv_peak_window_r);
        atv_cutoff_hz_nxt = cutoff_hz(atv_lowpass_select_r);
    end

    // Sample path registers.
    always @(posedge clk) begin
        if (!resetn) begin
            prev_seg_r <= `HDTR_SEG_NONE;
            debt_r <= `HDTR_RST_OFFSET;
            seg_open_r <= 1'h0;
            out_valid <= 1'h0;
            out_amp <= 8'h00;
            out_seg <= `HDTR_SEG_NONE;
            out_len <= 9'h000;
            out_ms <= 16'h0000;
        end else begin
            prev_seg_r <= prev_seg_nxt;
            debt_r <= debt_nxt;
            seg_open_r <= seg_open_nxt;
            out_valid <= out_valid_nxt;
            out_amp <= out_amp_nxt;
            out_seg <= out_seg_nxt;
            out_len <= out_len_nxt;
            out_ms <= out_ms_nxt;
        end
    end

    // Audio outputs; the decodes follow a control write one edge later.
    always @(posedge clk) begin
        if (!resetn) begin
            atv_valid <= 1'h0;
            atv_level <= 8'h00;
            atv_peak_ms <= `HDTR_PEAK_MS0;
            atv_cutoff_hz <= `HDTR_LP_HZ1;
        end else begin
            atv_valid <= atv_valid_nxt;
            atv_level <= atv_level_nxt;
            atv_peak_ms <= atv_peak_ms_nxt;
            atv_cutoff_hz <= atv_cutoff_hz_nxt;
        end
    end

endmodule

// ---- bench/hdtr_regs_props.sv ----
/*
 * Concurrent checks on the sample, audio and decode ports of hdtr_regs.
 * Assumes the bind at the foot of this file and a synchronous active-low reset.
 */
`include "hdtr_map.vh"

module hdtr_regs_props (
    input wire logic clk, // Device clock.
    input wire logic resetn, // Reset, active low.
    input wire logic [7:0] reg_addr, // Register address.
    input wire logic reg_wr, // Write strobe.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic closed_loop, // Closed-loop drive.
    input wire logic smp_valid, // Sample strobe.
    input wire logic wave_start, // First sample of a waveform.
    input wire logic [7:0] smp_amp, // Sample amplitude.
    input wire logic [7:0] smp_len, // Sample length.
    input wire logic smp_overdrive, // Overdrive flag.
    input wire logic [7:0] wave_min_amp, // Most negative amplitude.
    input wire logic [4:0] sample_step_time, // Sample_step_time.
    input wire logic out_valid, // Adjusted sample strobe.
    input wire logic [2:0] out_seg, // Segment class.
    input wire logic [8:0] out_len, // Adjusted length.
    input wire logic [15:0] out_ms, // Adjusted length in ms.
    input wire logic audio_valid, // Audio strobe.
    input wire logic [7:0] audio_level, // Audio level.
    input wire logic atv_valid, // Audio passed strobe.
    input wire logic [7:0] atv_level, // Passed level.
    input wire logic [5:0] atv_peak_ms, // Peak window.
    input wire logic [7:0] atv_cutoff_hz // Cutoff.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_out_strobe: assert property (smp_valid |=> out_valid)
        else $error("out_valid missing after a sample");
    chk_ms_product: assert property (out_valid |->
        out_ms == {7'h00, out_len} * {11'h000, $past(sample_step_time)})
        else $error("out_ms is not out_len times the interval");
    chk_seg_overdrive: assert property (smp_valid && smp_overdrive |=> out_seg == `HDTR_SEG_OVERDRIVE)
        else $error("overdrive sample misclassified");
    chk_seg_positive: assert property (smp_valid && !smp_overdrive && !smp_amp[7] && smp_amp != 8'h00
        |=> out_seg == `HDTR_SEG_POS)
        else $error("positive sample not in positive sustain");
    chk_seg_negative: assert property (smp_valid && !smp_overdrive && smp_amp[7] && smp_amp != wave_min_amp
        |=> out_seg == `HDTR_SEG_NEG)
        else $error("negative sample not in negative sustain");
    chk_seg_brake: assert property (smp_valid && !smp_overdrive && smp_amp[7] && smp_amp == wave_min_amp
        |=> out_seg == `HDTR_SEG_BRAKE)
        else $error("most negative sample not in brake");
    chk_brake_closed: assert property (smp_valid && wave_start && closed_loop && !smp_overdrive
        && smp_amp[7] && smp_amp == wave_min_amp |=> out_len == {1'b0, $past(smp_len)})
        else $error("brake offset applied in closed loop");
    chk_atv_pass: assert property (atv_valid |-> $past(audio_valid) && atv_level == $past(audio_level))
        else $error("atv_valid without a matching audio sample");
    chk_atv_hold: assert property (!audio_valid |=> $stable(atv_level))
        else $error("atv_level changed without audio sample");
    chk_decode_range: assert property (atv_peak_ms inside {6'h0A, 6'h14, 6'h1E, 6'h28}
        && atv_cutoff_hz inside {8'h64, 8'h7D, 8'h96, 8'hC8})
        else $error("decode output outside its table");
    chk_peak_decode: assert property (reg_wr && reg_addr == `HDTR_ADDR_ATV_CTRL |=> ##1
        atv_peak_ms == 6'h0A * ({4'h0, $past(reg_wdata[3:2], 2)} + 6'h01))
        else $error("peak window does not follow the control write");
endmodule

bind hdtr_regs hdtr_regs_props hdtr_regs_props_inst (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata,
    .closed_loop, .smp_valid, .wave_start,
    .smp_amp, .smp_len, .smp_overdrive, .wave_min_amp, .sample_step_time, .out_valid, .out_seg, .out_len,
    .out_ms, .audio_valid, .audio_level, .atv_valid, .atv_level, .atv_peak_ms, .atv_cutoff_hz);

// ---- bench/hdtr_regs_tb.sv ----
/*
 * Self-checking bench for hdtr_regs: register access, segment retiming and the audio floor.
 * Assumes the design files under logic/ and the checker are compiled before it.
 */
module hdtr_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, reg_wr, reg_rd, closed_loop, smp_valid, wave_start, smp_overdrive, audio_valid;
    logic [7:0] reg_addr, reg_wdata, smp_amp, smp_len, wave_min_amp, audio_level;
    logic [4:0] sample_step_time;
    wire [7:0] reg_rdata, out_amp, atv_level, atv_cutoff_hz;
    wire out_valid, atv_valid;
    wire [2:0] out_seg;
    wire [8:0] out_len;
    wire [15:0] out_ms;
    wire [5:0] atv_peak_ms;
    int err_count, comparisons, i;
    logic [15:0] hz [4] = '{16'h0064, 16'h007D, 16'h0096, 16'h00C8};

    hdtr_regs hdtr_regs_inst (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .closed_loop,
        .smp_valid, .wave_start, .smp_amp, .smp_len, .smp_overdrive, .wave_min_amp, .sample_step_time, .out_valid,
        .out_amp, .out_seg, .out_len, .out_ms, .audio_valid, .audio_level, .atv_valid, .atv_level, .atv_peak_ms,
        .atv_cutoff_hz);

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        cmp(reg_rdata, e);
    endtask

    // Sends one sample and checks the adjusted result; the interval is fixed at 3 ms.
    task automatic smp(input logic [7:0] amp, input logic [7:0] len, input logic ov, input logic st,
            input logic [2:0] es, input logic [8:0] el);
        @(negedge clk);
        smp_valid = 1'b1;
        smp_amp = amp;
        smp_len = len;
        smp_overdrive = ov;
        wave_start = st;
        @(negedge clk);
        smp_valid = 1'b0;
        wave_start = 1'b0;
        cmp(out_valid, 16'h0001);
        cmp(out_amp, amp);
        cmp(out_seg, es);
        cmp(out_len, el);
        cmp(out_ms, {7'h00, el} * 16'h0003);
    endtask

    task automatic aud(input logic [7:0] lvl, input logic pass, input logic [7:0] el);
        @(negedge clk);
        audio_valid = 1'b1;
        audio_level = lvl;
        @(negedge clk);
        audio_valid = 1'b0;
        cmp(atv_valid, pass);
        cmp(atv_level, el);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(50 * 4000);
        err_count++;
        summarize();
    end

    initial begin
        {reg_wr, reg_rd, closed_loop, smp_valid, wave_start, smp_overdrive, audio_valid} = 7'h00;
        {reg_addr, reg_wdata, smp_amp, smp_len, audio_level} = 40'h00;
        wave_min_amp = 8'h80;
        sample_step_time = 5'h03;
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h01);
        rd(8'h12, 8'h19);
        rd(8'h13, 8'h00);
        cmp(atv_peak_ms, 16'h000A);
        cmp(atv_cutoff_hz, 16'h007D);
        $display("test reset values done");
        for (i = 0; i < 16; i++) begin
            wr(8'h11, 8'hF0 | i[7:0]);
            rd(8'h11, {4'h0, i[3:0]});
            cmp(atv_peak_ms, 16'h000A * (i / 4 + 1));
            cmp(atv_cutoff_hz, hz[i % 4]);
        end
        $display("test audio control decode done");
        wr(8'h0E, 8'hFE);
        rd(8'h0E, 8'hFE);
        smp(8'h40, 8'h03, 1'b0, 1'b1, 3'h2, 9'h001);
        smp(8'h40, 8'h03, 1'b0, 1'b0, 3'h2, 9'h003);
        smp(8'h7F, 8'h04, 1'b1, 1'b0, 3'h1, 9'h004);
        wr(8'h0E, 8'h02);
        smp(8'h10, 8'h03, 1'b0, 1'b1, 3'h2, 9'h005);
        wr(8'h0E, 8'hFB);
        smp(8'h10, 8'h03, 1'b0, 1'b1, 3'h2, 9'h000);
        smp(8'h10, 8'h03, 1'b0, 1'b0, 3'h2, 9'h001);
        smp(8'h00, 8'h04, 1'b0, 1'b0, 3'h0, 9'h004);
        $display("test positive sustain done");
        wr(8'h0F, 8'h03);
        wr(8'h10, 8'h04);
        rd(8'h0F, 8'h03);
        rd(8'h10, 8'h04);
        smp(8'hF0, 8'h02, 1'b0, 1'b1, 3'h3, 9'h005);
        smp(8'h80, 8'h02, 1'b0, 1'b0, 3'h4, 9'h006);
        smp(8'h80, 8'h02, 1'b0, 1'b0, 3'h4, 9'h002);
        closed_loop = 1'b1;
        smp(8'h80, 8'h02, 1'b0, 1'b1, 3'h4, 9'h002);
        smp(8'hF0, 8'h02, 1'b0, 1'b0, 3'h3, 9'h005);
        closed_loop = 1'b0;
        $display("test negative sustain and brake done");
        wr(8'h12, 8'h30);
        rd(8'h12, 8'h30);
        aud(8'h2F, 1'b0, 8'h00);
        aud(8'h30, 1'b1, 8'h30);
        aud(8'h31, 1'b1, 8'h31);
        aud(8'h20, 1'b0, 8'h31);
        $display("test audio floor done");
        summarize();
    end
endmodule
